// ===== src/count_clock_pkg.sv
package count_clock_pkg;

  // Register byte addresses on the CPU memory bus
  localparam logic [15:0] TIMER0_CLOCK_SELECT_ADDR = 16'hff71;
  localparam logic [15:0] TIMER1_CLOCK_SELECT_ADDR = 16'hff75;
  localparam logic [15:0] TIMER2_CLOCK_SELECT_ADDR = 16'hff79;

  // Field layout and reset value
  localparam int SEL_CODE_LSB = 0;
  localparam int SEL_CODE_W = 3;
  localparam logic [7:0] CLOCK_SELECT_RESET = 8'h00;
  localparam logic [7:0] SEL_CODE_MASK = 8'h07;

  // Counter count
  localparam int NUM_COUNTERS = 3;

  // Shared prescaler width: largest division is 2^11
  localparam int PRESCALE_W = 11;

  // Selection codes
  localparam logic [2:0] CODE_FALLING = 3'h0;
  localparam logic [2:0] CODE_RISING = 3'h1;

  // Division exponents for codes 2..7, per counter, packed 4 bits each
  // (code 2 in the lowest nibble)
  localparam logic [23:0] DIV_EXP_T0 = 24'hb97531;
  localparam logic [23:0] DIV_EXP_T1 = 24'h543210;
  localparam logic [23:0] DIV_EXP_T2 = 24'h987654;

  // Memory bus read/write request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  // Per-counter control from the mode registers
  typedef struct packed {
    logic run;
    logic chained;
  } counter_ctrl_t;

endpackage

// ===== src/event_edge_detect.sv
`timescale 1ns/1ps
module event_edge_detect
  import count_clock_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // Event pin and result
  input wire logic event_in,
  output logic rise_out,
  output logic fall_out
);

  logic sync_a;
  logic sync_b;
  logic prev;
  logic next_sync_a;
  logic next_sync_b;
  logic next_prev;

  // Two-stage synchroniser then one history stage; only sync_b and prev are inspected
  always_comb begin
    next_sync_a = event_in;
    next_sync_b = sync_a;
    next_prev = sync_b;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      prev <= next_prev;
    end
  end

  // One-cycle edge pulses
  assign rise_out = sync_b & ~prev;
  assign fall_out = ~sync_b & prev;

endmodule

// ===== src/timer_count_clock_select.sv
`timescale 1ns/1ps
// What this block does
// - Reset clears all three select registers
// - Codes 0/1 pick falling/rising event edge
// - Counter0 codes 2-7 divide by 2..2048
// - Counter1 codes 2-7 divide by 1..32
// - Counter2 codes 2-7 divide by 16..512
// - Divided sources come from system clock
// - Chained counter1 ignores its select code
// - Chained counter2 ignores its select code
// - Run cleared gates the enable; all runs cleared zeroes prescaler
module timer_count_clock_select
  import count_clock_pkg::*;
#(
  parameter int SEL_W = SEL_CODE_W
)
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // CPU memory bus
  input mem_req_t mem_req_in,
  output logic [7:0] mem_rdata_out,
  output logic mem_hit_out,
  // Counter control and event pins
  input counter_ctrl_t [NUM_COUNTERS-1:0] counter_ctrl_in,
  input wire logic [NUM_COUNTERS-1:0] event_input_in,
  // Count enables to counter0..counter2
  output logic [NUM_COUNTERS-1:0] count_enable_out,
  output logic [NUM_COUNTERS-1:0] chain_mode_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Select registers

  logic [7:0] clock_select [NUM_COUNTERS];
  logic [7:0] next_clock_select [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] addr_hit;

  // Address decode, one bit per register; the full 16-bit address is
  // compared so neighbouring mode registers never alias onto these
  always_comb begin
    addr_hit[0] = (mem_req_in.addr == TIMER0_CLOCK_SELECT_ADDR);
    addr_hit[1] = (mem_req_in.addr == TIMER1_CLOCK_SELECT_ADDR);
    addr_hit[2] = (mem_req_in.addr == TIMER2_CLOCK_SELECT_ADDR);
  end

  // Whole-byte write only; upper bits are stored as written, since the
  // decode below uses only the code field and software keeps them zero
  always_comb begin
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      next_clock_select[i] = clock_select[i];
      if (mem_req_in.wr && addr_hit[i]) begin
        next_clock_select[i] = mem_req_in.wdata;
      end
    end
  end

  // Select register bank, cleared by reset
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (srst_in) begin
        clock_select[i] <= CLOCK_SELECT_RESET;
      end else begin
        clock_select[i] <= next_clock_select[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data register

  logic [7:0] next_rdata;
  logic next_hit;
  logic [7:0] rdata;
  logic hit;

  // Unmapped addresses read as zero and hit stays low
  // A read in the same cycle as a write returns the old byte
  always_comb begin
    next_rdata = 8'h00;
    next_hit = 1'b0;
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (mem_req_in.rd && addr_hit[i]) begin
        next_rdata = clock_select[i];
        next_hit = 1'b1;
      end
    end
  end

  // Read answer register, stands for one cycle
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rdata <= 8'h00;
      hit <= 1'b0;
    end else begin
      rdata <= next_rdata;
      hit <= next_hit;
    end
  end

  assign mem_rdata_out = rdata;
  assign mem_hit_out = hit;

  ////////////////////////////////////////////////////////////////////////////
  // Shared free-running prescaler on the system clock

  logic [PRESCALE_W-1:0] prescale;
  logic [PRESCALE_W-1:0] next_prescale;
  logic [PRESCALE_W:0] tick;
  logic [NUM_COUNTERS-1:0] run_bits;
  logic any_run;

  // Gather the run controls so the prescaler gate follows NUM_COUNTERS
  for (genvar r = 0; r < NUM_COUNTERS; r++) begin : g_run
    assign run_bits[r] = counter_ctrl_in[r].run;
  end
  assign any_run = |run_bits;

  // Held at zero while no counter runs, so a restart begins a clean period.
  // Limitation: one shared stage means a counter restarted while another
  // keeps running joins the current prescaler phase, so its first divided
  // pulse may come early; the spacing between pulses is always exact.
  always_comb begin
    if (any_run) begin
      next_prescale = prescale + {{(PRESCALE_W-1){1'b0}}, 1'b1};
    end else begin
      next_prescale = '0;
    end
  end

  // Prescaler register
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      prescale <= '0;
    end else begin
      prescale <= next_prescale;
    end
  end

  // tick[k] pulses once every 2^k clocks; tick[0] is every clock.
  // Decoding all-ones low bits keeps every tick from tick[1] up one cycle wide.
  assign tick[0] = 1'b1;
  for (genvar k = 1; k <= PRESCALE_W; k++) begin : g_tick
    assign tick[k] = &prescale[k-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-counter source selection

  logic [NUM_COUNTERS-1:0] ev_rise;
  logic [NUM_COUNTERS-1:0] ev_fall;
  logic [NUM_COUNTERS-1:0] next_enable;
  logic [NUM_COUNTERS-1:0] enable;
  logic [NUM_COUNTERS-1:0] chained;

  // Exponent lookup for codes 2..7; codes 0 and 1 are caught by the
  // case below and never index the table
  function automatic logic [3:0] div_exp(input int unsigned idx, input logic [2:0] code);
    logic [23:0] table_bits;
    logic [2:0] slot;
    table_bits = (idx == 0) ? DIV_EXP_T0 : ((idx == 1) ? DIV_EXP_T1 : DIV_EXP_T2);
    slot = code - 3'h2;
    return table_bits[slot*4 +: 4];
  endfunction

  // Only counters 1 and 2 can be chained onto their lower neighbour;
  // a chained counter is clocked by its neighbour's overflow outside
  assign chained[0] = 1'b0;
  assign chained[1] = counter_ctrl_in[1].chained;
  assign chained[2] = counter_ctrl_in[2].chained;

  for (genvar g = 0; g < NUM_COUNTERS; g++) begin : g_src
    logic [SEL_W-1:0] code;

    // Event pin synchronised here; an edge reaches the enable three clocks
    // after the pin changes
    event_edge_detect u_edge (
      .ref_clk_in(ref_clk_in),
      .srst_in(srst_in),
      .event_in(event_input_in[g]),
      .rise_out(ev_rise[g]),
      .fall_out(ev_fall[g])
    );

    // Only the code field steers the source; upper bits are don't-care
    assign code = clock_select[g][SEL_CODE_LSB +: SEL_W];

    // Stopped or chained counters get no enable of their own
    always_comb begin
      if (!counter_ctrl_in[g].run || chained[g]) begin
        next_enable[g] = 1'b0;
      end else begin
        unique case (code)
          CODE_FALLING: next_enable[g] = ev_fall[g];
          CODE_RISING: next_enable[g] = ev_rise[g];
          default: next_enable[g] = tick[div_exp(g, code)];
        endcase
      end
    end
  end

  // Registered so the enable is a clean one-cycle pulse, except counter1 code 2 (divide by 1), which holds it high every cycle
  // Costs one cycle of latency but keeps decode glitches off the counters
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      enable <= '0;
    end else begin
      enable <= next_enable;
    end
  end

  assign count_enable_out = enable;
  assign chain_mode_out = chained;

endmodule

// ===== test/count_clock_sva.sv
`timescale 1ns/1ps
module count_clock_sva
  import count_clock_pkg::*;
(
  // Watched ports
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input mem_req_t mem_req_in,
  input wire logic [7:0] mem_rdata_out,
  input wire logic mem_hit_out,
  input counter_ctrl_t [NUM_COUNTERS-1:0] counter_ctrl_in,
  input wire logic [NUM_COUNTERS-1:0] event_input_in,
  input wire logic [NUM_COUNTERS-1:0] count_enable_out,
  input wire logic [NUM_COUNTERS-1:0] chain_mode_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  ////////////////////////////////////////
  // Bus answers one cycle after the request
  read_hit_a: assert property (mem_req_in.rd && mem_req_in.addr == 16'hff71 |=> mem_hit_out)
    else $error("mapped read gave no hit");
  miss_zero_a: assert property (mem_req_in.rd && mem_req_in.addr == 16'hff72
    |=> !mem_hit_out && mem_rdata_out == 8'h00) else $error("unmapped read answered");
  write_read_a: assert property (mem_req_in.wr && mem_req_in.addr == TIMER2_CLOCK_SELECT_ADDR
    ##1 !mem_req_in.wr ##1 mem_req_in.rd && mem_req_in.addr == TIMER2_CLOCK_SELECT_ADDR
    |=> mem_rdata_out == $past(mem_req_in.wdata, 3)) else $error("read back differs");
  ////////////////////////////////////////
  // Enables gated by chaining and run, counter0 enable width, chain mode copy
  chain1_quiet_a: assert property (counter_ctrl_in[1].chained [*2] |=> !count_enable_out[1])
    else $error("chained counter1 enabled");
  chain2_quiet_a: assert property (counter_ctrl_in[2].chained [*2] |=> !count_enable_out[2])
    else $error("chained counter2 enabled");
  stop_quiet_a: assert property (!counter_ctrl_in[0].run [*2] |=> !count_enable_out[0])
    else $error("stopped counter0 enabled");
  pulse_single_a: assert property (count_enable_out[0] |=> !count_enable_out[0])
    else $error("counter0 enable wider than one cycle");
  chain_copy_a: assert property (chain_mode_out ==
    {counter_ctrl_in[2].chained, counter_ctrl_in[1].chained, 1'b0}) else $error("chain copy");
  // Main scenarios reached
  cover property (count_enable_out[0]);
  cover property (mem_hit_out);
  cover property (chain_mode_out[1]);
endmodule

// ===== test/timer_counters_model.sv
`timescale 1ns/1ps
module timer_counters_model
  import count_clock_pkg::*;
(
  // Clock
  input wire logic ref_clk_in,
  // Control and count pulses
  input counter_ctrl_t [NUM_COUNTERS-1:0] ctrl_in,
  input wire logic [NUM_COUNTERS-1:0] enable_in,
  // Counter values
  output logic [NUM_COUNTERS-1:0][7:0] count_out
);
  // Stopped counters sit at zero; chaining not modelled, bench only compares deltas
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (!ctrl_in[i].run) begin
        count_out[i] <= 8'h00;
      end else if (enable_in[i]) begin
        count_out[i] <= count_out[i] + 8'h01;
      end
    end
  end
endmodule

// ===== test/test_timer_count_clock_select.sv
`timescale 1ns/1ps
module test_timer_count_clock_select;
  import count_clock_pkg::*;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  mem_req_t req = '0;
  counter_ctrl_t [NUM_COUNTERS-1:0] ctrl = '0;
  logic [2:0] ev = 3'h0;
  logic [7:0] rdata;
  logic hit;
  logic [2:0] en;
  logic [2:0] chain;
  logic [2:0][7:0] cnt;
  logic [15:0] base;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  logic [15:0] addr [3] = '{TIMER0_CLOCK_SELECT_ADDR, TIMER1_CLOCK_SELECT_ADDR,
    TIMER2_CLOCK_SELECT_ADDR};
  // Design and counters beyond it
  timer_count_clock_select uut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .mem_req_in(req),
    .mem_rdata_out(rdata), .mem_hit_out(hit), .counter_ctrl_in(ctrl), .event_input_in(ev),
    .count_enable_out(en), .chain_mode_out(chain));
  timer_counters_model partner (.ref_clk_in(ref_clk_in), .ctrl_in(ctrl), .enable_in(en),
    .count_out(cnt));
  ////////////////////////////////////////
  // Clock and hang guard; the whole run needs about 8k cycles
  initial begin
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      results();
    end
  end
  ////////////////////////////////////////
  // Compare, bus cycles and measurements
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_in) req = '{1'b1, 1'b0, a, d};
    @(negedge ref_clk_in) req = '0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [8:0] exp);
    @(negedge ref_clk_in) req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge ref_clk_in) req = '0;
    check(16'({hit, rdata}), 16'(exp));
  endtask
  // Counter stopped around the write, never changed while running
  task automatic sel(input int i, input int c);
    @(negedge ref_clk_in) ctrl[i].run = 1'b0;
    wr(addr[i], 8'(c));
    ctrl[i].run = 1'b1;
    rd(addr[i], {1'b1, 8'(c)});
  endtask
  task automatic period(input int i, input int k);
    int n;
    n = 0;
    while (en[i] !== 1'b1 && n < 5000) begin
      @(negedge ref_clk_in);
      n++;
    end
    @(negedge ref_clk_in);
    n = 1;
    while (en[i] !== 1'b1 && n < 5000) begin
      @(negedge ref_clk_in);
      n++;
    end
    check(16'(n), 16'(1 << k));
  endtask
  task automatic results;
    $display("checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(negedge ref_clk_in);
    srst_in = 1'b0;
    for (int i = 0; i < 3; i++) rd(addr[i], 9'h100);
    rd(16'hff72, 9'h000);
    wr(16'hff72, 8'h05);
    rd(addr[0], 9'h100);
    for (int i = 0; i < 3; i++) begin
      for (int c = 2; c < 8; c++) begin
        sel(i, c);
        period(i, i == 0 ? 2 * c - 3 : (i == 1 ? c - 2 : c + 2));
      end
    end
    // Each edge kind counted once, the other ignored
    for (int i = 0; i < 3; i++) begin
      for (int c = 0; c < 2; c++) begin
        sel(i, c);
        repeat (2) begin
          @(negedge ref_clk_in) base = 16'(cnt[i]);
          ev[i] = ~ev[i];
          repeat (8) @(negedge ref_clk_in);
          check(16'(cnt[i]) - base, 16'(ev[i] == c[0]));
        end
      end
    end
    sel(1, 2);
    sel(2, 2);
    @(negedge ref_clk_in) ctrl[1].chained = 1'b1;
    ctrl[2].chained = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    base = {cnt[2], cnt[1]};
    repeat (64) @(negedge ref_clk_in);
    check({cnt[2], cnt[1]}, base);
    check(16'(chain), 16'h0006);
    // Second reset while counters run
    srst_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    srst_in = 1'b0;
    for (int i = 0; i < 3; i++) rd(addr[i], 9'h100);
    results();
  end
endmodule
bind timer_count_clock_select count_clock_sva chk (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
  .mem_req_in(mem_req_in), .mem_rdata_out(mem_rdata_out), .mem_hit_out(mem_hit_out),
  .counter_ctrl_in(counter_ctrl_in), .event_input_in(event_input_in),
  .count_enable_out(count_enable_out), .chain_mode_out(chain_mode_out));
